// File: inc/pdc_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: shared constants for the loop and calibration register block
// Assumes: APB word addressing, register index = byte address / 4
// Notes:   group index sits above the three-bit offset within a group
//////////////////////////////////////////////////////////////////////////////
package pdc_pkg;

  // register index width (group in [4:3], offset in [2:0])
  localparam int unsigned IDX_W = 5;

  // register groups
  localparam logic [1:0] GRP_OSC = 2'h0;
  localparam logic [1:0] GRP_FAST = 2'h1;
  localparam logic [1:0] GRP_MEDIUM = 2'h2;

  // offsets inside the oscillator group
  localparam logic [2:0] OFS_SLOW_TRIM = 3'h4;
  localparam logic [2:0] OFS_MULT_CTRL = 3'h5;
  localparam logic [2:0] OFS_REF_SEL = 3'h6;

  // offsets inside each calibration loop group
  localparam logic [2:0] OFS_LOOP_CTRL = 3'h0;
  localparam logic [2:0] OFS_CAL_FINE = 3'h2;
  localparam logic [2:0] OFS_CAL_COARSE = 3'h3;
  localparam logic [2:0] OFS_RATIO_LOW = 3'h5;
  localparam logic [2:0] OFS_RATIO_HIGH = 3'h6;

  // multiplier control field positions
  localparam int unsigned MULT_SRC_LSB = 6;
  localparam int unsigned MULT_HALF_BIT = 5;
  localparam int unsigned MULT_FAC_LSB = 0;

  // reference select field positions
  localparam int unsigned REF_FAST_LSB = 1;
  localparam int unsigned REF_MED_BIT = 0;

  // multiplier input codes
  localparam logic [1:0] SRC_MEDIUM_OSC = 2'h0;
  localparam logic [1:0] SRC_RESERVED = 2'h1;
  localparam logic [1:0] SRC_FAST_OSC = 2'h2;
  localparam logic [1:0] SRC_EXTERNAL = 2'h3;

  // fast loop reference codes
  localparam logic [1:0] FREF_SLOW_OSC = 2'h0;
  localparam logic [1:0] FREF_WATCH_XTAL = 2'h1;
  localparam logic [1:0] FREF_FRAME_START = 2'h2;
  localparam logic [1:0] FREF_RESERVED = 2'h3;

  // values after reset, and the fine field upper limit
  localparam logic [7:0] MULT_CTRL_RST = 8'h00;
  localparam logic [2:0] REF_SEL_RST = 3'h0;
  localparam logic [15:0] COMP_FAST_RST = 16'h7a12;
  localparam logic [15:0] COMP_MEDIUM_RST = 16'h07a1;
  localparam logic [6:0] FINE_MAX = 7'h7f;

  // calibration loop sequencer states
  typedef enum logic [0:0] {LOOP_IDLE, LOOP_MEASURE} pdc_loop_state_t;

endpackage : pdc_pkg

// File: rtl/pdc_loop.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: frequency locked calibration sequencer for one oscillator
// Assumes: oscillator and reference levels already synchronised to pclk
// Notes:   oscillator must be well below pclk/2 to be counted exactly
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module pdc_loop (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control from the register file
  input wire logic enable,
  input wire logic [15:0] comp,
  // synchronised clock levels
  input wire logic osc_lvl,
  input wire logic ref_lvl,
  // status and step requests
  output logic running,
  output logic step_up,
  output logic step_down
);

  // sequencer state word
  typedef struct packed {
    pdc_pkg::pdc_loop_state_t state;
    logic osc_prev;
    logic ref_prev;
    logic [15:0] count;
    logic up;
    logic down;
  } pdc_loop_t;

  pdc_loop_t loop_reg;
  pdc_loop_t loop_next;
  logic osc_rise;
  logic ref_rise;

  // rising edges of the sampled clocks
  assign osc_rise = osc_lvl & ~loop_reg.osc_prev;
  assign ref_rise = ref_lvl & ~loop_reg.ref_prev;

  // count oscillator edges per reference period and judge the result
  always_comb
  begin
    loop_next = loop_reg;
    loop_next.osc_prev = osc_lvl;
    loop_next.ref_prev = ref_lvl;
    loop_next.up = 1'b0;
    loop_next.down = 1'b0;
    unique case (loop_reg.state)
      pdc_pkg::LOOP_IDLE:
      begin
        // start only on a reference edge so the first period is whole
        if (enable && ref_rise)
        begin
          loop_next.state = pdc_pkg::LOOP_MEASURE;
          loop_next.count = 16'h0000;
        end
      end
      pdc_pkg::LOOP_MEASURE:
      begin
        // saturate rather than wrap, a wrap would invert the step
        if (osc_rise && (loop_reg.count != 16'hffff))
          loop_next.count = loop_reg.count + 16'h0001;
        if (ref_rise)
        begin
          loop_next.up = (loop_reg.count < comp); // R21
          loop_next.down = (loop_reg.count > comp); // R21
          loop_next.count = 16'h0000;
          // stop only at a period end, so running lingers after disable
          if (!enable)
            loop_next.state = pdc_pkg::LOOP_IDLE; // R12
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      loop_reg <= '{state: pdc_pkg::LOOP_IDLE, default: '0};
    else
      loop_reg <= loop_next;
  end

  assign running = (loop_reg.state == pdc_pkg::LOOP_MEASURE);
  assign step_up = loop_reg.up;
  assign step_down = loop_reg.down;

endmodule : pdc_loop

// File: rtl/pdc_regs.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: multiplier and calibration loop registers behind an APB slave
// Assumes: factory words stable from reset release; clocks slow vs pclk
// Notes:   every access has one wait-free access phase after setup
//////////////////////////////////////////////////////////////////////////////
// Function
// R1: reset loads factory slow oscillator trim byte
// R2: slow trim writable anytime, drives trim
// R3: input select 00 medium,10 fast,11 external
// R4: no watch crystal input; external >=0.4MHz
// R5: half output bit divides multiplier by two
// R6: five bit factor, one to thirtyone
// R7: fast reference: slow, watch crystal, frame start
// R8: medium reference: slow osc or crystal
// R9: software enables chosen reference source separately
// R10: enable bit starts loop; others read zero
// R11: reference stable before software sets enable
// R12: enable reads one until loop stops
// R13: thirteen bit value, loop or manual writes
// R14: disabled loop: trim follows calibration registers
// R15: fine field factory loaded, loop adjusted, locked
// R16: coarse field factory loaded, loop never changes
// R17: software sets fine mid-range for new targets
// R18: two bytes form sixteen bit ratio compare
// R19: compare resets to nominal/1.024kHz ratio
// R20: software writes zero to reserved bits
// R21: loop steps fine field toward compare ratio
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module pdc_regs #(
  parameter int unsigned AW = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // factory words from the signature store
  input wire logic [7:0] factory_slow_trim,
  input wire logic [6:0] factory_fast_fine,
  input wire logic [5:0] factory_fast_coarse,
  input wire logic [6:0] factory_medium_fine,
  input wire logic [5:0] factory_medium_coarse,
  // asynchronous clock levels from the analog side
  input wire logic fast_osc_clk_in,
  input wire logic medium_osc_clk_in,
  input wire logic slow_osc_ref_in,
  input wire logic watch_crystal_ref_in,
  input wire logic frame_start_ref_in,
  // oscillator and multiplier controls
  output logic [7:0] slow_osc_trim,
  output logic [1:0] multiplier_input_select,
  output logic multiplier_half_output,
  output logic [4:0] multiplication_factor,
  output logic [1:0] fast_loop_reference_select,
  output logic medium_loop_reference_select,
  // calibration words {coarse, fine} and loop activity
  output logic [12:0] fast_osc_cal,
  output logic [12:0] medium_osc_cal,
  output logic [1:0] loop_active
);

  //////////////////////////////////////////////////////////////////////////
  // state, index 0 is the fast loop and index 1 the medium loop

  typedef struct packed {
    logic loaded;             // factory words taken
    logic [7:0] slow_trim;    // slow oscillator trim
    logic [7:0] mult_ctrl;    // source, half output, factor
    logic [2:0] ref_sel;      // fast ref [2:1], medium ref [0]
    logic [1:0] en;           // software enable per loop
    logic [1:0] active;       // enable readback, held while running
    logic [1:0][6:0] fine;    // fine calibration field
    logic [1:0][5:0] coarse;  // coarse calibration field
    logic [1:0][15:0] comp;   // ratio compare value
    logic [31:0] rdata;       // apb read data
    logic ready;              // apb ready
    logic err;                // apb error
  } pdc_regs_t;

  pdc_regs_t st_reg;
  pdc_regs_t st_next;

  localparam pdc_regs_t ST_RST = '{
    loaded: 1'b0,
    slow_trim: 8'h00,
    mult_ctrl: pdc_pkg::MULT_CTRL_RST,
    ref_sel: pdc_pkg::REF_SEL_RST,
    en: 2'h0,
    active: 2'h0,
    fine: '0,
    coarse: '0,
    comp: {pdc_pkg::COMP_MEDIUM_RST, pdc_pkg::COMP_FAST_RST},
    rdata: 32'h0000_0000,
    ready: 1'b0,
    err: 1'b0
  };

  //////////////////////////////////////////////////////////////////////////
  // address decode, shared by the read and write paths

  // true when the index names an implemented register
  function automatic logic reg_mapped(input logic [pdc_pkg::IDX_W-1:0] idx);
    logic [1:0] grp;
    logic [2:0] ofs;
    grp = idx[4:3];
    ofs = idx[2:0];
    if (grp == pdc_pkg::GRP_OSC)
      reg_mapped = (ofs == pdc_pkg::OFS_SLOW_TRIM) || (ofs == pdc_pkg::OFS_MULT_CTRL)
                   || (ofs == pdc_pkg::OFS_REF_SEL);
    else if ((grp == pdc_pkg::GRP_FAST) || (grp == pdc_pkg::GRP_MEDIUM))
      reg_mapped = (ofs == pdc_pkg::OFS_LOOP_CTRL) || (ofs == pdc_pkg::OFS_CAL_FINE)
                   || (ofs == pdc_pkg::OFS_CAL_COARSE) || (ofs == pdc_pkg::OFS_RATIO_LOW)
                   || (ofs == pdc_pkg::OFS_RATIO_HIGH);
    else
      reg_mapped = 1'b0;
  endfunction : reg_mapped

  logic [pdc_pkg::IDX_W-1:0] idx;
  logic [1:0] grp;
  logic [2:0] ofs;
  logic lp;          // loop addressed by a loop group
  logic setup;       // apb setup cycle
  logic wr;          // write takes effect this edge
  logic [7:0] wbyte; // low byte lane of the write
  logic [7:0] rbyte; // selected read byte

  assign idx = paddr[pdc_pkg::IDX_W+1:2];
  assign grp = idx[4:3];
  assign ofs = idx[2:0];
  assign lp = grp[1];
  assign setup = psel & ~penable;
  // only lane 0 carries data, so a write without it changes nothing
  assign wr = psel & penable & st_reg.ready & pwrite & pstrb[0] & reg_mapped(idx);
  assign wbyte = pwdata[7:0];

  //////////////////////////////////////////////////////////////////////////
  // synchronisers and the two calibration sequencers

  logic [4:0] clk_sync;
  logic fast_ref_lvl;
  logic medium_ref_lvl;
  logic [1:0] run;
  logic [1:0] up;
  logic [1:0] down;

  pdc_sync #(
    .W(5)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({frame_start_ref_in, watch_crystal_ref_in, slow_osc_ref_in,
               medium_osc_clk_in, fast_osc_clk_in}),
    .sync_out(clk_sync)
  );

  // route the selected reference, reserved code gives no reference
  always_comb
  begin
    unique case (st_reg.ref_sel[2:1])
      pdc_pkg::FREF_SLOW_OSC: fast_ref_lvl = clk_sync[2]; // R7
      pdc_pkg::FREF_WATCH_XTAL: fast_ref_lvl = clk_sync[3]; // R7
      pdc_pkg::FREF_FRAME_START: fast_ref_lvl = clk_sync[4]; // R7
      pdc_pkg::FREF_RESERVED: fast_ref_lvl = 1'b0;
    endcase
    medium_ref_lvl = st_reg.ref_sel[0] ? clk_sync[3] : clk_sync[2]; // R8
  end

  pdc_loop u_fast_loop (
    .pclk(pclk),
    .presetn(presetn),
    .enable(st_reg.en[0]),
    .comp(st_reg.comp[0]),
    .osc_lvl(clk_sync[0]),
    .ref_lvl(fast_ref_lvl),
    .running(run[0]),
    .step_up(up[0]),
    .step_down(down[0])
  );

  pdc_loop u_medium_loop (
    .pclk(pclk),
    .presetn(presetn),
    .enable(st_reg.en[1]),
    .comp(st_reg.comp[1]),
    .osc_lvl(clk_sync[1]),
    .ref_lvl(medium_ref_lvl),
    .running(run[1]),
    .step_up(up[1]),
    .step_down(down[1])
  );

  //////////////////////////////////////////////////////////////////////////
  // read multiplexer, unused bits read as zero

  always_comb
  begin
    rbyte = 8'h00;
    if (grp == pdc_pkg::GRP_OSC)
    begin
      if (ofs == pdc_pkg::OFS_SLOW_TRIM)
        rbyte = st_reg.slow_trim;
      else if (ofs == pdc_pkg::OFS_MULT_CTRL)
        rbyte = st_reg.mult_ctrl;
      else if (ofs == pdc_pkg::OFS_REF_SEL)
        rbyte = {5'h00, st_reg.ref_sel};
    end
    else
    begin
      if (ofs == pdc_pkg::OFS_LOOP_CTRL)
        rbyte = {7'h00, st_reg.active[lp]}; // R10 R12
      else if (ofs == pdc_pkg::OFS_CAL_FINE)
        rbyte = {1'b0, st_reg.fine[lp]};
      else if (ofs == pdc_pkg::OFS_CAL_COARSE)
        rbyte = {2'h0, st_reg.coarse[lp]};
      else if (ofs == pdc_pkg::OFS_RATIO_LOW)
        rbyte = st_reg.comp[lp][7:0]; // R18
      else if (ofs == pdc_pkg::OFS_RATIO_HIGH)
        rbyte = st_reg.comp[lp][15:8]; // R18
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // next state: factory load, loop steps, bus writes, bus answer

  always_comb
  begin
    st_next = st_reg;
    // factory words are taken on the first edge after reset release
    if (!st_reg.loaded)
    begin
      st_next.loaded = 1'b1;
      st_next.slow_trim = factory_slow_trim; // R1
      st_next.fine = {factory_medium_fine, factory_fast_fine}; // R15
      st_next.coarse = {factory_medium_coarse, factory_fast_coarse}; // R16
    end
    // enable readback stays high until the sequencer reports idle
    st_next.active = st_reg.en | run; // R12
    // the sequencer only ever moves the fine field, coarse is left alone
    for (int i = 0; i < 2; i++)
    begin
      if (up[i] && (st_reg.fine[i] != pdc_pkg::FINE_MAX))
        st_next.fine[i] = st_reg.fine[i] + 7'h01; // R21
      else if (down[i] && (st_reg.fine[i] != 7'h00))
        st_next.fine[i] = st_reg.fine[i] - 7'h01; // R21
    end
    // register writes
    if (wr)
    begin
      if (grp == pdc_pkg::GRP_OSC)
      begin
        if (ofs == pdc_pkg::OFS_SLOW_TRIM)
          st_next.slow_trim = wbyte; // R2
        else if (ofs == pdc_pkg::OFS_MULT_CTRL)
        begin
          // a reserved source code keeps the previous source
          if (wbyte[pdc_pkg::MULT_SRC_LSB +: 2] != pdc_pkg::SRC_RESERVED)
            st_next.mult_ctrl[pdc_pkg::MULT_SRC_LSB +: 2] =
              wbyte[pdc_pkg::MULT_SRC_LSB +: 2]; // R3
          st_next.mult_ctrl[pdc_pkg::MULT_HALF_BIT] = wbyte[pdc_pkg::MULT_HALF_BIT]; // R5
          st_next.mult_ctrl[pdc_pkg::MULT_FAC_LSB +: 5] =
            wbyte[pdc_pkg::MULT_FAC_LSB +: 5]; // R6
        end
        else if (ofs == pdc_pkg::OFS_REF_SEL)
        begin
          st_next.ref_sel[2:1] = wbyte[pdc_pkg::REF_FAST_LSB +: 2]; // R7
          st_next.ref_sel[0] = wbyte[pdc_pkg::REF_MED_BIT]; // R8
        end
      end
      else if (ofs == pdc_pkg::OFS_LOOP_CTRL)
        st_next.en[lp] = wbyte[0]; // R10
      else if (ofs == pdc_pkg::OFS_CAL_FINE)
      begin
        // locked while the loop runs, manual trim only when disabled
        if (!st_reg.active[lp])
          st_next.fine[lp] = wbyte[6:0]; // R13 R15
      end
      else if (ofs == pdc_pkg::OFS_CAL_COARSE)
      begin
        if (!st_reg.active[lp])
          st_next.coarse[lp] = wbyte[5:0]; // R13 R16
      end
      else if (ofs == pdc_pkg::OFS_RATIO_LOW)
        st_next.comp[lp][7:0] = wbyte; // R18
      else if (ofs == pdc_pkg::OFS_RATIO_HIGH)
        st_next.comp[lp][15:8] = wbyte; // R18
    end
    // answer in the cycle after setup; data latched at setup
    st_next.ready = setup;
    st_next.err = setup & ~reg_mapped(idx);
    if (setup)
      st_next.rdata = {24'h00_0000, reg_mapped(idx) ? rbyte : 8'h00};
  end

  // state register, compare words start at their nominal ratios
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= ST_RST; // R19
    else
      st_reg <= st_next;
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs, each straight from the state register

  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = st_reg.err;
  assign slow_osc_trim = st_reg.slow_trim;
  assign multiplier_input_select = st_reg.mult_ctrl[pdc_pkg::MULT_SRC_LSB +: 2];
  assign multiplier_half_output = st_reg.mult_ctrl[pdc_pkg::MULT_HALF_BIT];
  assign multiplication_factor = st_reg.mult_ctrl[pdc_pkg::MULT_FAC_LSB +: 5];
  assign fast_loop_reference_select = st_reg.ref_sel[2:1];
  assign medium_loop_reference_select = st_reg.ref_sel[0];
  // trim follows the register pair whether the loop runs or not
  assign fast_osc_cal = {st_reg.coarse[0], st_reg.fine[0]}; // R14
  assign medium_osc_cal = {st_reg.coarse[1], st_reg.fine[1]}; // R14
  assign loop_active = st_reg.active;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  factory_load_a: assert property ($rose(st_reg.loaded) |-> // R1
    slow_osc_trim == $past(factory_slow_trim) && st_reg.comp[0] == pdc_pkg::COMP_FAST_RST)
    else $error("factory trim not loaded");
  trim_write_a: assert property (wr && grp == pdc_pkg::GRP_OSC // R2
    && ofs == pdc_pkg::OFS_SLOW_TRIM |=> slow_osc_trim == $past(pwdata[7:0]))
    else $error("slow trim write lost");
  reserved_source_a: assert property (wr && grp == pdc_pkg::GRP_OSC // R3
    && ofs == pdc_pkg::OFS_MULT_CTRL && pwdata[7:6] == pdc_pkg::SRC_RESERVED
    |=> $stable(multiplier_input_select) && multiplication_factor == $past(pwdata[4:0]))
    else $error("reserved source accepted");
  enable_hold_a: assert property (run[0] |=> loop_active[0]) // R12
    else $error("enable dropped while running");
  coarse_locked_a: assert property (st_reg.loaded && st_reg.active[1] |=> // R16
    $stable(st_reg.coarse[1]))
    else $error("coarse changed while loop active");
  fine_step_a: assert property (up[0] && st_reg.fine[0] != pdc_pkg::FINE_MAX // R21
    |=> st_reg.fine[0] == $past(st_reg.fine[0]) + 7'h01)
    else $error("fine step up missed");
  ctrl_read_a: assert property (setup && grp == pdc_pkg::GRP_FAST // R10
    && ofs == pdc_pkg::OFS_LOOP_CTRL |=> pready && prdata == {31'h0, $past(loop_active[0])})
    else $error("loop control readback wrong");
  fine_lock_a: assert property (wr && st_reg.active[0] && !up[0] && !down[0] // R15
    && grp == pdc_pkg::GRP_FAST && ofs == pdc_pkg::OFS_CAL_FINE |=> $stable(st_reg.fine[0]))
    else $error("fine written while loop active");
  bus_error_a: assert property (setup && !reg_mapped(idx) |=> pready && pslverr)
    else $error("unmapped access not refused");

  loop_step_c: cover property (up[0] ##[1:50] down[0]);
  disable_wait_c: cover property ($fell(st_reg.en[1]) ##1 run[1] ##1 loop_active[1]);
  unmapped_c: cover property (pready && pslverr);

endmodule : pdc_regs

// File: rtl/pdc_sync.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: two-flop synchroniser for asynchronous level inputs
// Assumes: each bit is an independent level, no bus coherency needed
// Notes:   first stage is read only by the second stage
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module pdc_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // both stages kept in one state word
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } pdc_sync_t;

  pdc_sync_t sync_reg;
  pdc_sync_t sync_next;

  // shift the input through the two stages
  always_comb
  begin
    sync_next = sync_reg;
    sync_next.meta = async_in;
    sync_next.stable = sync_reg.meta;
  end

  // state register, cleared on reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_reg <= '0;
    else
      sync_reg <= sync_next;
  end

  assign sync_out = sync_reg.stable;

endmodule : pdc_sync

// File: tb/pdc_regs_tb.sv
////////////////////////////////////////////////////////////
// Purpose: self-checking bench for the loop and calibration registers
// Assumes: zero wait state slave, bench-made oscillator and reference levels
// Notes:   all three references share one slow level so any non-reserved select works
////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module pdc_regs_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr; // byte address
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] trim; // slow trim output
  logic [1:0] msel, fref, act;
  logic mhalf, mref;
  logic rf = 1'b0, fo = 1'b0, mo = 1'b0; // bench-made clock levels
  logic [4:0] mfac;
  logic [12:0] fcal, mcal; // {coarse, fine}
  logic [7:0] cnt = 8'h00; // level generator
  int errors = 0, compares = 0, cyc = 0;
  pdc_regs i_pdc_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .factory_slow_trim(8'h5a),
    .factory_fast_fine(7'h33), .factory_fast_coarse(6'h15),
    .factory_medium_fine(7'h2a), .factory_medium_coarse(6'h0c),
    .fast_osc_clk_in(fo), .medium_osc_clk_in(mo), .slow_osc_ref_in(rf),
    .watch_crystal_ref_in(rf), .frame_start_ref_in(rf), .slow_osc_trim(trim),
    .multiplier_input_select(msel), .multiplier_half_output(mhalf),
    .multiplication_factor(mfac), .fast_loop_reference_select(fref),
    .medium_loop_reference_select(mref), .fast_osc_cal(fcal), .medium_osc_cal(mcal),
    .loop_active(act));
  ////////////////////////////////////////////////////////////
  // clock; osc periods 8 and 16 cycles, reference 128, well below pclk/2
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cnt <= cnt + 8'h01;
    fo <= cnt[2];
    mo <= cnt[3];
    rf <= cnt[6];
    cyc <= cyc + 1;
    if (cyc == 20000) // a hang ends the run
    begin
      errors++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////
  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
      begin
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
        errors++;
      end
  endtask : chk
  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // lets the release land before the next setup
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, {24'h0, exp});
  endtask : rdc
  ////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    chk(trim, 8'h5a);
    chk(fcal, {6'h15, 7'h33});
    chk(mcal, {6'h0c, 7'h2a});
    rdc(12'h034, 8'h12);
    rdc(12'h038, 8'h7a);
    rdc(12'h020, 8'h00);
    rdc(12'h018, 8'h00);
    rdc(12'h014, 8'h00);
  endtask : t_reset
  task automatic t_mult;
    logic [1:0] c [3] = '{2'h0, 2'h2, 2'h3};
    wr(12'h010, 8'ha5);
    chk(trim, 8'ha5);
    foreach (c[i])
    begin
      wr(12'h014, {c[i], 1'b1, 5'd31});
      chk({msel, mhalf, mfac}, {c[i], 1'b1, 5'd31});
    end
    wr(12'h014, {2'h1, 1'b0, 5'd1}); // reserved source is refused
    chk({msel, mhalf, mfac}, {2'h3, 1'b0, 5'd1});
    for (int r = 0; r < 4; r++)
    begin
      wr(12'h018, {5'h0, r[1:0], 1'b1});
      chk({fref, mref}, {r[1:0], 1'b1});
    end
    wr(12'h018, 8'h00);
  endtask : t_mult
  task automatic t_manual;
    logic [31:0] r;
    logic e;
    wr(12'h028, 8'h40);
    wr(12'h02c, 8'h21);
    chk(fcal, {6'h21, 7'h40});
    wr(12'h048, 8'h3f);
    chk(mcal, {6'h0c, 7'h3f});
    apb(1'b0, 12'h07c, 8'h00, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask : t_manual
  task automatic t_loop;
    logic [6:0] f0;
    int n;
    wr(12'h038, 8'h00); // compare 0: loop must step fine down
    wr(12'h034, 8'h00);
    wr(12'h020, 8'h01);
    wr(12'h040, 8'h01);
    repeat (400) @(posedge pclk);
    chk(act[0], 1'b1);
    chk(act[1], 1'b1);
    wr(12'h028, 8'h7f); // all three writes blocked while running
    wr(12'h02c, 8'h00);
    wr(12'h04c, 8'h3f);
    chk(fcal[12:7], 6'h21);
    chk(mcal[12:7], 6'h0c);
    chk(mcal[6:0] > 7'h3f, 1'b1);
    chk(fcal[6:0] < 7'h40, 1'b1);
    f0 = fcal[6:0];
    wr(12'h038, 8'hff); // largest compare: loop must step up
    wr(12'h034, 8'hff);
    repeat (400) @(posedge pclk);
    chk(fcal[6:0] > f0, 1'b1);
    wr(12'h040, 8'h00);
    wr(12'h020, 8'h00);
    chk(act[0], 1'b1);
    n = 0;
    while (act[0] !== 1'b0 && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
    rdc(12'h020, 8'h00);
    rdc(12'h040, 8'h00);
    wr(12'h028, 8'h11);
    chk(fcal, {6'h21, 7'h11});
  endtask : t_loop
  ////////////////////////////////////////////////////////////
  // verdict
  task automatic results;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_mult();
    t_manual();
    t_loop();
    results();
  end
endmodule : pdc_regs_tb
